// file: pixel_stream_map.svh
// constants for the pixel stream engine and its host transfer partner
// assumes a 20 MHz system clock shared by both ends
`ifndef PIXEL_STREAM_MAP_SVH
`define PIXEL_STREAM_MAP_SVH
`define PX_ACTIVE_W 480
`define PX_ACTIVE_H 272
`define PX_FRAME_RATE_HZ 60
`define PX_CLK_HZ 20000000
`define PX_FRAME_CYCLES (`PX_CLK_HZ / `PX_FRAME_RATE_HZ)
`define PX_DEF_DIV 2
`define PX_DEF_HTOTAL 525
`define PX_DEF_VTOTAL 286
`define PX_DEF_HSYNC 41
`define PX_DEF_VSYNC 10
`define PX_DEF_HSTART 43
`define PX_DEF_VSTART 12
`define PX_DEF_MODE24 1'b0
`define PX_CFG_BITS 73
`define PX_BURST_WORDS 8
`define PX_FIFO_DEPTH 64
`define PX_SPI_WORD_HDIV 2
`endif

// file: pixel_stream_pkg.sv
// types shared by the pixel stream engine and the host transfer end
// no assumptions beyond the constant header
`default_nettype none
package pixel_stream_pkg;
  typedef logic [23:0] pixel_t;
  typedef struct packed {
    logic [7:0] div;
    logic [11:0] htotal;
    logic [11:0] vtotal;
    logic [11:0] hsync;
    logic [11:0] vsync;
    logic [7:0] hstart;
    logic [7:0] vstart;
  } timing_s;
endpackage
`default_nettype wire

// file: pixel_link_if.sv
// link between host transfer end and pixel engine: spi config load and dma handshake
// both ends share clk_sys; the testbench supplies the clock
`default_nettype none
interface pixel_link_if (
  input wire logic clk_sys
);
  logic cfgSclk;
  logic cfgMosi;
  logic cfgCsN;
  logic cfgDone;
  logic transferRequestN;
  logic transferAcknowledgeN;
  logic [23:0] transferData;
  modport engine (
    input clk_sys, cfgSclk, cfgMosi, cfgCsN, transferAcknowledgeN, transferData,
    output cfgDone, transferRequestN
  );
  modport host (
    input clk_sys, cfgDone, transferRequestN,
    output cfgSclk, cfgMosi, cfgCsN, transferAcknowledgeN, transferData
  );
endinterface
`default_nettype wire

// file: lcd_pixel_stream_engine.sv
// Function
// R1 - refresh panel continuously near sixty frames/second
// R2 - frame 480x272, default sixteen-bit rgb565 pixels
// R3 - optional 24-bit mode doubles per-pixel transfer; here one 24-bit transferData word per pixel in both modes
// R4 - fly-by burst writes land in pixel fifo
// R5 - drain fifo at fixed configured pixel rate
// R6 - engine generates all panel timing itself
// R7 - run only after spi configuration download
// R8 - host streams frame only per request/acknowledge
// R9 - host reads sdram continuous single-cycle mode
// R10 - request low while fifo fits a burst; here low only while it has room for a burst plus 4 words
// holds the engine end: spi config loader, pixel fifo, panel timing generator
// assumes the host spi pins arrive asynchronously and are synchronised here; ack and data come on clk_sys and are not
`include "pixel_stream_map.svh"
`default_nettype none
module lcd_pixel_stream_engine
  import pixel_stream_pkg::*;
#(
  parameter int FIFO_DEPTH = `PX_FIFO_DEPTH,
  parameter int BURST_WORDS = `PX_BURST_WORDS
) (
  input wire logic clk_sys,
  input wire logic reset,
  // host link
  pixel_link_if.engine link,
  // panel
  output logic panelPixClk,
  output logic panelHsync,
  output logic panelVsync,
  output logic panelDe,
  output logic [23:0] panelRgb,
  // status
  output logic underflow,
  output logic mode24
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int CW = `PX_CFG_BITS;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } state_e;

  typedef struct packed {
    state_e st;
    logic [2:0] sclkSync;
    logic [1:0] csSync;
    logic [1:0] mosiSync;
    logic [CW-1:0] shift;
    logic [6:0] bitCnt;
    timing_s tim;
    logic m24;
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic [7:0] divCnt;
    logic [11:0] hCnt;
    logic [11:0] vCnt;
    logic pixClk;
    logic hs;
    logic vs;
    logic de;
    logic [23:0] rgb;
    logic under;
    logic reqN;
    logic done;
  } state_s;

  state_s q, d;
  pixel_t mem [FIFO_DEPTH];
  logic wrEn;
  logic [AW:0] level;

  function automatic logic [23:0] expand565(input logic [15:0] p);
    expand565 = {p[15:11], p[15:13], p[10:5], p[10:9], p[4:0], p[4:2]};
  endfunction

  assign level = q.wrPtr - q.rdPtr;
  // ack and data come from host flops on clk_sys, so they are taken in the ack cycle itself;
  // acks may run back to back, so a late sample would pick up the next word instead
  assign wrEn = (q.st == ST_RUN) && !link.transferAcknowledgeN; // [R4]

  always_ff @(posedge clk_sys)
  begin
    if (wrEn)
    begin
      mem[q.wrPtr[AW-1:0]] <= link.transferData; // [R4]
    end
  end

  always_comb
  begin
    logic pixTick;
    logic lineEnd;
    logic inH;
    logic inV;
    logic [23:0] word;
    pixTick = 1'b0;
    lineEnd = 1'b0;
    inH = 1'b0;
    inV = 1'b0;
    word = mem[q.rdPtr[AW-1:0]];
    d = q;
    d.sclkSync = {q.sclkSync[1:0], link.cfgSclk};
    d.csSync = {q.csSync[0], link.cfgCsN};
    d.mosiSync = {q.mosiSync[0], link.cfgMosi};
    case (q.st)
      ST_LOAD:
      begin
        // shift on rising sclk while select is low; use stage 2 and 3 for edge
        if (!q.csSync[1] && q.sclkSync[1] && !q.sclkSync[2])
        begin
          d.shift = {q.shift[CW-2:0], q.mosiSync[1]}; // [R7]
          d.bitCnt = q.bitCnt + 7'h01;
        end
        if (q.csSync[1] && q.bitCnt == 7'(CW))
        begin
          d.tim = q.shift[CW-1:1];
          d.m24 = q.shift[0]; // [R3]
          d.st = ST_RUN; // [R7]
          d.done = 1'b1;
        end
        else if (q.csSync[1])
        begin
          d.bitCnt = 7'h00;
        end
      end
      ST_RUN:
      begin
        if (wrEn)
        begin
          d.wrPtr = q.wrPtr + 1'b1;
        end
        // pixel clock divided from clk_sys by the loaded divider
        if (q.divCnt >= q.tim.div - 8'h01)
        begin
          d.divCnt = 8'h00;
          pixTick = 1'b1; // [R5] [R6]
        end
        else
        begin
          d.divCnt = q.divCnt + 8'h01;
        end
        d.pixClk = (q.divCnt < (q.tim.div >> 1)); // [R6]
        if (pixTick)
        begin
          lineEnd = (q.hCnt == q.tim.htotal - 12'h001);
          d.hCnt = lineEnd ? 12'h000 : q.hCnt + 12'h001; // [R1]
          if (lineEnd)
          begin
            d.vCnt = (q.vCnt == q.tim.vtotal - 12'h001) ? 12'h000 : q.vCnt + 12'h001; // [R1]
          end
          d.hs = !(q.hCnt < q.tim.hsync); // [R6]
          d.vs = !(q.vCnt < q.tim.vsync); // [R6]
          inH = (q.hCnt >= 12'(q.tim.hstart)) && (q.hCnt < 12'(q.tim.hstart) + 12'(`PX_ACTIVE_W)); // [R2]
          inV = (q.vCnt >= 12'(q.tim.vstart)) && (q.vCnt < 12'(q.tim.vstart) + 12'(`PX_ACTIVE_H)); // [R2]
          d.de = inH && inV;
          d.rgb = 24'h000000;
          if (inH && inV)
          begin
            if (level != '0)
            begin
              d.rgb = q.m24 ? word : expand565(word[15:0]); // [R2] [R3]
              d.rdPtr = q.rdPtr + 1'b1; // [R5]
            end
            else
            begin
              d.under = 1'b1;
            end
          end
        end
        // leave room for acks still in flight through the synchroniser
        d.reqN = !(level <= (AW+1)'(FIFO_DEPTH - BURST_WORDS - 4)); // [R10]
      end
      ST_HOLD:
      begin
        d.st = ST_RUN;
      end
      default:
      begin
        d.st = ST_LOAD;
      end
    endcase
    if (reset)
    begin
      d = '0;
      d.st = ST_LOAD;
      d.reqN = 1'b1;
      d.hs = 1'b1;
      d.vs = 1'b1;
      d.csSync = 2'b11;
      d.tim.div = 8'(`PX_DEF_DIV);
      d.tim.htotal = 12'(`PX_DEF_HTOTAL);
      d.tim.vtotal = 12'(`PX_DEF_VTOTAL);
      d.m24 = `PX_DEF_MODE24;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    q <= d;
  end

  assign panelPixClk = q.pixClk;
  assign panelHsync = q.hs;
  assign panelVsync = q.vs;
  assign panelDe = q.de;
  assign panelRgb = q.rgb;
  assign underflow = q.under;
  assign mode24 = q.m24;
  assign link.transferRequestN = q.reqN; // [R10]
  assign link.cfgDone = q.done;
endmodule // lcd_pixel_stream_engine
`default_nettype wire

// file: lcd_host_dma.sv
// holds the host end: spi configuration download, then frame streaming on request
// assumes the frame buffer is a read port supplied by the user whose data for fbAddr is ready within the same clk_sys cycle
`include "pixel_stream_map.svh"
`default_nettype none
module lcd_host_dma
  import pixel_stream_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  // user side
  input wire logic start,
  input wire logic [`PX_CFG_BITS-1:0] cfgImage,
  output logic [17:0] fbAddr,
  input wire logic [23:0] fbData,
  output logic busy,
  // engine link
  pixel_link_if.host link
);
  localparam logic [17:0] FRAME_WORDS = 18'(`PX_ACTIVE_W * `PX_ACTIVE_H);

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_CFG = 4'b0010,
    H_WAITDONE = 4'b0100,
    H_STREAM = 4'b1000
  } hstate_e;

  typedef struct packed {
    hstate_e st;
    logic [6:0] bitCnt;
    logic [1:0] phase;
    logic sclk;
    logic mosi;
    logic csN;
    logic [1:0] reqSync;
    logic [1:0] doneSync;
    logic [17:0] addr;
    logic ackN;
    logic [23:0] data;
  } host_s;

  host_s q, d;

  always_comb
  begin
    d = q;
    d.reqSync = {q.reqSync[0], link.transferRequestN};
    d.doneSync = {q.doneSync[0], link.cfgDone};
    d.ackN = 1'b1;
    case (q.st)
      H_IDLE:
      begin
        if (start)
        begin
          d.st = H_CFG;
          d.csN = 1'b0;
          d.bitCnt = 7'h00;
          d.phase = 2'b00;
          d.mosi = cfgImage[`PX_CFG_BITS-1]; // [R7]
        end
      end
      H_CFG:
      begin
        d.phase = q.phase + 2'b01;
        if (q.phase == 2'b01)
        begin
          d.sclk = 1'b1;
        end
        if (q.phase == 2'b11)
        begin
          d.sclk = 1'b0;
          d.bitCnt = q.bitCnt + 7'h01;
          if (q.bitCnt == 7'(`PX_CFG_BITS - 1))
          begin
            d.csN = 1'b1;
            d.st = H_WAITDONE; // [R7]
          end
          else
          begin
            d.mosi = cfgImage[7'(`PX_CFG_BITS - 2) - q.bitCnt];
          end
        end
      end
      H_WAITDONE:
      begin
        if (q.doneSync[1])
        begin
          d.st = H_STREAM;
        end
      end
      H_STREAM:
      begin
        // one word per acknowledge while requested, wrapping the frame forever
        if (!q.reqSync[1])
        begin
          d.ackN = 1'b0; // [R8]
          d.data = fbData; // [R9]
          d.addr = (q.addr == FRAME_WORDS - 18'h00001) ? 18'h00000 : q.addr + 18'h00001; // [R8]
        end
      end
      default:
      begin
        d.st = H_IDLE;
      end
    endcase
    if (reset)
    begin
      d = '0;
      d.st = H_IDLE;
      d.csN = 1'b1;
      d.ackN = 1'b1;
      d.reqSync = 2'b11;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    q <= d;
  end

  assign fbAddr = q.addr;
  assign busy = (q.st != H_IDLE);
  assign link.cfgSclk = q.sclk;
  assign link.cfgMosi = q.mosi;
  assign link.cfgCsN = q.csN;
  assign link.transferAcknowledgeN = q.ackN; // [R8]
  assign link.transferData = q.data;
endmodule // lcd_host_dma
`default_nettype wire

// file: lcd_link_checker.sv
// assertions on the link between the host end and the engine end
// instantiated beside the interface by the testbench
`default_nettype none
module lcd_link_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link
  input wire logic cfgSclk,
  input wire logic cfgCsN,
  input wire logic cfgDone,
  input wire logic transferRequestN,
  input wire logic transferAcknowledgeN
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  chk_no_early_request: assert property (!cfgDone |-> transferRequestN)
    else $error("request before load");
  chk_done_holds: assert property (cfgDone |=> cfgDone)
    else $error("load flag dropped");
  chk_ack_after_load: assert property (!transferAcknowledgeN |-> cfgDone)
    else $error("ack before load");
  chk_ack_needs_request: assert property (transferRequestN [*8] |=> transferAcknowledgeN)
    else $error("ack without request");
  chk_sclk_idle: assert property (cfgCsN |-> !cfgSclk)
    else $error("serial clock outside frame");
  chk_cs_after_load: assert property (cfgDone |-> cfgCsN)
    else $error("select low after load");
  chk_done_after_cs: assert property ($rose(cfgDone) |-> $past(cfgCsN, 2))
    else $error("load flag while selected");
  // no disable here: this one speaks of the reset itself
  chk_reset_state: assert property (disable iff (1'b0)
    reset |=> !cfgDone && transferRequestN && transferAcknowledgeN && cfgCsN)
    else $error("bad reset state");
  cover property ($rose(cfgDone));
  cover property (!transferRequestN ##3 !transferAcknowledgeN);
  cover property (!transferAcknowledgeN ##1 !transferAcknowledgeN);
endmodule // lcd_link_checker
`default_nettype wire

// file: lcd_pixel_stream_engine_tb.sv
// testbench: host end loads the engine, then a partial frame is streamed
// assumes package, interface, both ends and the checker compiled first
`default_nettype none
module lcd_pixel_stream_engine_tb
  import pixel_stream_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic [72:0] cfgImage = '0;
  logic [72:0] img;
  logic [23:0] fbData = '0;
  logic [23:0] salt = '0;
  logic [23:0] panelRgb, lastRgb = '0;
  logic [17:0] fbAddr;
  logic busy, panelHsync, panelVsync, panelDe, underflow, mode24;
  logic lastDe = 1'b0, lastHs = 1'b1, deSeen = 1'b0;
  int failures = 0, num_checks = 0, cyc = 0;
  int pixIdx = 0, lineCyc = 0, deCyc = 0, lines = 0;
  // 600 x 278 at div 2 gives close to sixty frames
  timing_s tm = '{div: 8'h02, htotal: 12'h258, vtotal: 12'h116, hsync: 12'h029,
                  vsync: 12'h002, hstart: 8'h2B, vstart: 8'h04};
  pixel_link_if link (.clk_sys(clk_sys));
  lcd_pixel_stream_engine #(.FIFO_DEPTH(64), .BURST_WORDS(8)) lcd_pixel_stream_engine_inst (
    .clk_sys(clk_sys), .reset(reset), .link(link), .panelPixClk(), .panelHsync(panelHsync),
    .panelVsync(panelVsync), .panelDe(panelDe), .panelRgb(panelRgb), .underflow(underflow), .mode24(mode24));
  lcd_host_dma lcd_host_dma_inst (.clk_sys(clk_sys), .reset(reset), .start(start), .cfgImage(cfgImage),
    .fbAddr(fbAddr), .fbData(fbData), .busy(busy), .link(link));
  lcd_link_checker lcd_link_checker_inst (.clk_sys(clk_sys), .reset(reset), .cfgSclk(link.cfgSclk),
    .cfgCsN(link.cfgCsN), .cfgDone(link.cfgDone), .transferRequestN(link.transferRequestN),
    .transferAcknowledgeN(link.transferAcknowledgeN));
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end
  // unique words so a change of output marks a new pixel
  function automatic logic [23:0] pix(input logic [17:0] a);
    return {6'h00, a} ^ salt;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      failures++;
      complete_run();
    end
  end
  // frame buffer updated on the falling edge, half a cycle after fbAddr, plus the panel model
  always @(negedge clk_sys)
  begin
    fbData <= pix(fbAddr);
    if (!reset)
    begin
      lineCyc++;
      if (panelDe)
      begin
        deCyc++;
        deSeen = 1'b1;
      end
      if (panelDe && (!lastDe || panelRgb !== lastRgb))
      begin
        check(panelRgb, pix(18'(pixIdx)), "pixel");
        pixIdx++;
      end
      if (!panelHsync && lastHs)
      begin
        if (lines > 1)
          check(24'(lineCyc), 24'd1200, "line period");
        if (lines > 1 && deCyc > 0)
          check(24'(deCyc), 24'd960, "active width");
        lines = link.cfgDone ? lines + 1 : 0;
        lineCyc = 0;
        deCyc = 0;
      end
      lastDe = panelDe;
      lastRgb = panelRgb;
      lastHs = panelHsync;
    end
  end
  initial
  begin
    void'($urandom(32'h8277));
    salt = 24'($urandom);
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    repeat (400) @(negedge clk_sys);
    check({23'h0, deSeen}, 24'h0, "panel active before load");
    check({23'h0, link.transferRequestN}, 24'h1, "request before load");
    $display("test idle done");
    img = {tm, 1'b1};
    cfgImage = img;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    for (int i = 0; i < 400 && link.cfgDone !== 1'b1; i++)
      @(negedge clk_sys);
    check({23'h0, link.cfgDone}, 24'h1, "load flag");
    check({23'h0, mode24}, 24'h1, "wide mode");
    $display("test load done");
    for (int i = 0; i < 30000 && lines < 10; i++)
      @(negedge clk_sys);
    check(24'(lines), 24'd10, "lines seen");
    check({23'h0, underflow}, 24'h0, "underflow");
    $display("test stream done");
    complete_run();
  end
endmodule // lcd_pixel_stream_engine_tb
`default_nettype wire
